//--- src/tmr2_regs.svh
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH

// Byte addresses: printed offsets are not all multiples of four, so each is
// kept as an index and the byte address is four times the index.
`define TMR2_IDX_CONTROL 8'hc8
`define TMR2_IDX_CAP_LO 8'hca
`define TMR2_IDX_CAP_HI 8'hcb
`define TMR2_IDX_CNT_LO 8'hcc
`define TMR2_IDX_CNT_HI 8'hcd
`define TMR2_IDX_CLKCTL 8'h8e
`define TMR2_IDX_SERCLK 8'hd0

// Control register fields
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXF 6
`define TMR2_BIT_RCLK 5
`define TMR2_BIT_TRANSMIT_CLOCK_SELECT 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_CT 1
`define TMR2_BIT_CPRL 0
// Divider select sits at bit 5 of the clock control register
`define TMR2_BIT_DIVSEL 5
`define TMR2_CLKCTL_MASK 8'h38

`define TMR2_RESET_BYTE 8'h00
`define TMR2_DIV12 4'hb
`define TMR2_DIV2 4'h1

`endif

//--- src/tmr2_pkg.sv
package tmr2_pkg;
  typedef enum logic [1:0] {
    TMR2_MODE_OFF = 2'b00,
    TMR2_MODE_CAPTURE = 2'b01,
    TMR2_MODE_RELOAD = 2'b10,
    TMR2_MODE_BAUD = 2'b11
  } tmr2_mode_t;
endpackage

//--- src/tmr2_edge.sv
// Synchroniser and falling edge strobe for one pin
module tmr2_edge (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and strobe
  input wire logic pin,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign fall = last_reg & ~sync_reg;
endmodule

//--- src/tmr2_top.sv
`include "tmr2_regs.svh"
module tmr2_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  // Serial port and core
  input wire logic timer1_overflow,
  output logic rx_shift_clock,
  output logic tx_shift_clock,
  output logic timer2_irq
);
  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic known(input logic [11:0] a);
    known = hit(a, `TMR2_IDX_CONTROL) | hit(a, `TMR2_IDX_CAP_LO) |
            hit(a, `TMR2_IDX_CAP_HI) | hit(a, `TMR2_IDX_CNT_LO) |
            hit(a, `TMR2_IDX_CNT_HI) | hit(a, `TMR2_IDX_CLKCTL) |
            hit(a, `TMR2_IDX_SERCLK);
  endfunction

  logic [7:0] control_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] count_low_byte_reg;
  logic [7:0] count_high_byte_reg;
  logic [7:0] capture_low_byte_reg;
  logic [7:0] capture_high_byte_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  logic rx_pulse_reg;
  logic tx_pulse_reg;
  logic [3:0] div_reg;

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  logic wr_go;
  logic wr_lane0;
  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lane0 = wr_go && wstrb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      // Unmapped addresses answer with a slave error and store nothing
      bresp_reg <= known(awaddr_reg) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  logic wr_ctl;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  assign wr_ctl = wr_lane0 && hit(awaddr_reg, `TMR2_IDX_CONTROL);
  assign wr_cnt_lo = wr_lane0 && hit(awaddr_reg, `TMR2_IDX_CNT_LO);
  assign wr_cnt_hi = wr_lane0 && hit(awaddr_reg, `TMR2_IDX_CNT_HI);

  // ****************************************
  // Mode decode and time base
  // ****************************************
  tmr2_pkg::tmr2_mode_t mode;
  always_comb begin
    if (!control_reg[`TMR2_BIT_RUN]) begin
      mode = tmr2_pkg::TMR2_MODE_OFF;
    end else if (control_reg[`TMR2_BIT_RCLK] || control_reg[`TMR2_BIT_TRANSMIT_CLOCK_SELECT]) begin
      mode = tmr2_pkg::TMR2_MODE_BAUD;
    end else if (control_reg[`TMR2_BIT_CPRL]) begin
      mode = tmr2_pkg::TMR2_MODE_CAPTURE;
    end else begin
      mode = tmr2_pkg::TMR2_MODE_RELOAD;
    end
  end

  logic count_fall;
  logic trig_fall;
  tmr2_edge u_count_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(count_input_pin),
    .fall(count_fall)
  );
  tmr2_edge u_trig_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(trigger_pin),
    .fall(trig_fall)
  );

  // Divider free-runs so the time base phase does not depend on writes
  logic baud_mode;
  logic [3:0] div_top;
  assign baud_mode = (mode == tmr2_pkg::TMR2_MODE_BAUD);
  assign div_top = baud_mode ? `TMR2_DIV2 : `TMR2_DIV12;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 4'h0;
    end else if (div_reg >= div_top) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  logic tick;
  always_comb begin
    if (control_reg[`TMR2_BIT_CT]) begin
      tick = count_fall;
    end else if (baud_mode) begin
      tick = (div_reg == 4'h0);
    end else if (clock_control_reg[`TMR2_BIT_DIVSEL]) begin
      tick = 1'b1;
    end else begin
      tick = (div_reg == 4'h0);
    end
  end

  // ****************************************
  // Counter, capture and reload
  // ****************************************
  logic running;
  logic [15:0] count;
  logic [15:0] reload_val;
  logic ovf;
  logic trig;
  logic do_reload;
  logic do_capture;
  assign running = (mode != tmr2_pkg::TMR2_MODE_OFF);
  assign count = {count_high_byte_reg, count_low_byte_reg};
  assign reload_val = {capture_high_byte_reg, capture_low_byte_reg};
  assign ovf = running && tick && (count == 16'hffff);
  assign trig = running && trig_fall && control_reg[`TMR2_BIT_EXEN];
  assign do_capture = trig && (mode == tmr2_pkg::TMR2_MODE_CAPTURE);
  assign do_reload = (ovf && mode != tmr2_pkg::TMR2_MODE_CAPTURE) ||
                     (trig && mode == tmr2_pkg::TMR2_MODE_RELOAD);

  logic [15:0] count_next;
  always_comb begin
    if (do_reload) begin
      count_next = reload_val;
    end else if (running && tick) begin
      count_next = count + 16'h0001;
    end else begin
      count_next = count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_low_byte_reg <= `TMR2_RESET_BYTE;
      count_high_byte_reg <= `TMR2_RESET_BYTE;
    end else begin
      count_low_byte_reg <= wr_cnt_lo ? wdata_reg[7:0] : count_next[7:0];
      count_high_byte_reg <= wr_cnt_hi ? wdata_reg[7:0] : count_next[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_low_byte_reg <= `TMR2_RESET_BYTE;
      capture_high_byte_reg <= `TMR2_RESET_BYTE;
    end else if (wr_lane0 && hit(awaddr_reg, `TMR2_IDX_CAP_LO)) begin
      capture_low_byte_reg <= wdata_reg[7:0];
    end else if (wr_lane0 && hit(awaddr_reg, `TMR2_IDX_CAP_HI)) begin
      capture_high_byte_reg <= wdata_reg[7:0];
    end else if (do_capture) begin
      capture_low_byte_reg <= count_low_byte_reg;
      capture_high_byte_reg <= count_high_byte_reg;
    end
  end

  // ****************************************
  // Control and clock control registers
  // ****************************************
  // A software write replaces the whole byte, flags included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= `TMR2_RESET_BYTE;
    end else if (wr_ctl) begin
      control_reg <= wdata_reg[7:0];
    end else begin
      if (ovf && !baud_mode) begin
        control_reg[`TMR2_BIT_OVF] <= 1'b1;
      end
      if (trig) begin
        control_reg[`TMR2_BIT_EXF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_control_reg <= `TMR2_RESET_BYTE;
    end else if (wr_lane0 && hit(awaddr_reg, `TMR2_IDX_CLKCTL)) begin
      clock_control_reg <= wdata_reg[7:0] & `TMR2_CLKCTL_MASK;
    end
  end

  // ****************************************
  // Serial clocks and interrupt request
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_pulse_reg <= 1'b0;
      tx_pulse_reg <= 1'b0;
    end else begin
      rx_pulse_reg <= control_reg[`TMR2_BIT_RCLK] ? (ovf && baud_mode) : timer1_overflow;
      tx_pulse_reg <= control_reg[`TMR2_BIT_TRANSMIT_CLOCK_SELECT] ? (ovf && baud_mode) : timer1_overflow;
    end
  end
  assign rx_shift_clock = rx_pulse_reg;
  assign tx_shift_clock = tx_pulse_reg;
  assign timer2_irq = control_reg[`TMR2_BIT_OVF] | control_reg[`TMR2_BIT_EXF];

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit(s_axi_araddr, `TMR2_IDX_CONTROL)) begin
      rd_byte = control_reg;
    end else if (hit(s_axi_araddr, `TMR2_IDX_CAP_LO)) begin
      rd_byte = capture_low_byte_reg;
    end else if (hit(s_axi_araddr, `TMR2_IDX_CAP_HI)) begin
      rd_byte = capture_high_byte_reg;
    end else if (hit(s_axi_araddr, `TMR2_IDX_CNT_LO)) begin
      rd_byte = count_low_byte_reg;
    end else if (hit(s_axi_araddr, `TMR2_IDX_CNT_HI)) begin
      rd_byte = count_high_byte_reg;
    end else if (hit(s_axi_araddr, `TMR2_IDX_CLKCTL)) begin
      rd_byte = clock_control_reg;
    end else if (hit(s_axi_araddr, `TMR2_IDX_SERCLK)) begin
      rd_byte = {6'h00, rx_pulse_reg, tx_pulse_reg};
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= known(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

//--- dv/tmr2_assertions.sv
module tmr2_assertions (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Core side
  input logic timer2_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bus and flag relations
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  // Both halves are held one edge after the handshake; the answer follows one edge later
  property p_wr_ans;
    s_wr_both |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_end;
    s_wr_done |=> !s_axi_bvalid;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write answer stuck");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while answering");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready;
  endproperty
  a_r_byte: assert property (p_r_byte) else $error("read word malformed");
  // Flags only fall when software writes the control register
  property p_irq_fall;
    $fell(timer2_irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("flag cleared by hardware");
endmodule

//--- dv/tmr2_serial_model.sv
module tmr2_serial_model #(
  parameter int T1_PERIOD = 50
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial port side
  output logic timer1_overflow,
  input wire logic rx_shift_clock,
  input wire logic tx_shift_clock,
  // Pulse tallies
  output int rx_seen,
  output int tx_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int div;
  // Slow free-running timer 1 so its pulses are easy to tell from timer 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 0;
      timer1_overflow <= 1'b0;
      rx_seen <= 0;
      tx_seen <= 0;
    end else begin
      div <= (div == T1_PERIOD - 1) ? 0 : div + 1;
      timer1_overflow <= (div == T1_PERIOD - 1);
      rx_seen <= rx_seen + int'(rx_shift_clock);
      tx_seen <= tx_seen + int'(tx_shift_clock);
    end
  end
endmodule

//--- dv/tb_top.sv
`include "tmr2_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTL = 12'(4 * `TMR2_IDX_CONTROL);
  localparam logic [11:0] A_CAPL = 12'(4 * `TMR2_IDX_CAP_LO);
  localparam logic [11:0] A_CAPH = 12'(4 * `TMR2_IDX_CAP_HI);
  localparam logic [11:0] A_CNTL = 12'(4 * `TMR2_IDX_CNT_LO);
  localparam logic [11:0] A_CNTH = 12'(4 * `TMR2_IDX_CNT_HI);
  localparam logic [11:0] A_CLK = 12'(4 * `TMR2_IDX_CLKCTL);
  localparam logic [11:0] A_SER = 12'(4 * `TMR2_IDX_SERCLK);
  // Serial status reads zero here because the first slow timer 1 pulse comes later
  localparam logic [11:0] REGS [7] = '{A_CTL, A_CAPL, A_CAPH, A_CNTL, A_CNTH, A_CLK, A_SER};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic count_input_pin = 1'b1, trigger_pin = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic timer1_overflow, rx_shift_clock, tx_shift_clock, timer2_irq;
  int rx_seen, tx_seen, failures = 0, samples_checked = 0, cycles = 0;
  always #12.5 aclk = ~aclk;
  tmr2_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin, .trigger_pin,
    .timer1_overflow, .rx_shift_clock, .tx_shift_clock, .timer2_irq);
  tmr2_serial_model i_ser (.aclk, .aresetn, .timer1_overflow, .rx_shift_clock,
    .tx_shift_clock, .rx_seen, .tx_seen);
  // ****************************************
  // Bus, pin and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Handshakes are judged on the values standing at the rising edge itself
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0,
    input logic [3:0] st = 4'hf);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(posedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic pulse(input logic trig);
    @(posedge aclk);
    if (trig) trigger_pin <= 1'b0;
    else count_input_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    trigger_pin <= 1'b1;
    count_input_pin <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
  // Rate class: 2 for timer 2 baud overflows, 1 for the slow timer 1 pulses
  function automatic logic [31:0] rate(input int n);
    return (n > 50) ? 32'h2 : (n > 4) ? 32'h1 : 32'h0;
  endfunction
  task automatic serial_run(input logic [7:0] ctl, input logic [31:0] erx, input logic [31:0] etx);
    int r0, t0;
    axi_wr(A_CTL, ctl);
    r0 = rx_seen;
    t0 = tx_seen;
    repeat (400) @(posedge aclk);
    chk(rate(rx_seen - r0), erx);
    chk(rate(tx_seen - t0), etx);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (REGS[i]) axi_rd(REGS[i], 32'h0);
    axi_rd(12'h000, 32'h0, 2'h2);
    axi_wr(12'h000, 8'h5a, 2'h2);
    axi_wr(A_CAPL, 8'hf0);
    axi_wr(A_CAPH, 8'hff);
    axi_wr(A_CAPL, 8'h11, 2'h0, 4'he);
    axi_rd(A_CAPL, 32'hf0);
    axi_wr(A_CNTL, 8'hf0);
    axi_wr(A_CNTH, 8'hff);
    axi_wr(A_CTL, 8'h04);
    repeat (100) @(posedge aclk);
    axi_rd(A_CTL, 32'h04);
    repeat (200) @(posedge aclk);
    axi_rd(A_CTL, 32'h84);
    chk(32'(timer2_irq), 32'h1);
    axi_wr(A_CLK, 8'h20);
    axi_rd(A_CLK, 32'h20);
    repeat (100) @(posedge aclk);
    axi_rd(A_CNTH, 32'hff);
    axi_wr(A_CTL, 8'h0b);
    chk(32'(timer2_irq), 32'h0);
    axi_wr(A_CNTL, 8'h34);
    axi_wr(A_CNTH, 8'h12);
    pulse(1'b0);
    axi_wr(A_CTL, 8'h0f);
    repeat (3) pulse(1'b0);
    pulse(1'b1);
    axi_rd(A_CAPL, 32'h37);
    axi_rd(A_CAPH, 32'h12);
    axi_rd(A_CTL, 32'h4f);
    axi_wr(A_CTL, 8'h07);
    pulse(1'b0);
    pulse(1'b1);
    axi_rd(A_CTL, 32'h07);
    axi_rd(A_CAPL, 32'h37);
    axi_wr(A_CTL, 8'h0e);
    pulse(1'b0);
    pulse(1'b1);
    axi_rd(A_CNTL, 32'h37);
    axi_rd(A_CTL, 32'h4e);
    axi_wr(A_CTL, 8'h00);
    axi_wr(A_CLK, 8'h00);
    axi_wr(A_CAPL, 8'hfe);
    axi_wr(A_CAPH, 8'hff);
    axi_wr(A_CNTH, 8'hff);
    axi_wr(A_CNTL, 8'hfe);
    serial_run(8'h00, 32'h1, 32'h1);
    serial_run(8'h25, 32'h2, 32'h1);
    serial_run(8'h14, 32'h1, 32'h2);
    serial_run(8'h34, 32'h2, 32'h2);
    axi_rd(A_CTL, 32'h34);
    axi_wr(A_CTL, 8'h3c);
    pulse(1'b1);
    axi_rd(A_CTL, 32'h7c);
    report_and_stop();
  end
endmodule
bind tmr2_top tmr2_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer2_irq);
